// file: inc/sssp_defines.svh
// Register offsets, field positions, reset values and timing counts
// of the synchronous serial shift port. Included by the package users.
`ifndef SSSP_DEFINES_SVH
`define SSSP_DEFINES_SVH

`define SSSP_ADDR_W        8
`define SSSP_OFF_CTRL      8'h00
`define SSSP_OFF_STAT      8'h04
`define SSSP_OFF_DATA      8'h08
`define SSSP_OFF_PORTG     8'h0c

`define SSSP_STAT_BUSY     0
`define SSSP_STAT_SCK      1
`define SSSP_STAT_CNT_LSB  4

`define SSSP_CTRL_RST      4'h0
`define SSSP_PORTG_RST     4'h0
`define SSSP_DATA_RST      8'h00

// Half periods of the shift clock in instruction cycles
`define SSSP_HALF_DIV2     3'h1
`define SSSP_HALF_DIV4     3'h2
`define SSSP_HALF_DIV8     3'h4
`define SSSP_BITS          4'h8
`define SSSP_LAST_BIT      4'h7

`define SSSP_RESP_OKAY     2'h0
`define SSSP_RESP_SLVERR   2'h2

`endif

// file: inc/sssp_pkg.sv
// Types of the synchronous serial shift port.
// Assumes sssp_defines.svh for the numeric constants.
package sssp_pkg;

  // Field order matches the register bit positions, bit 0 last
  typedef struct packed {
    logic irq_en;
    logic clk_rate_sel_hi;
    logic clk_rate_sel_lo;
    logic serial_port_select;
  } sssp_ctrl_s;

  typedef struct packed {
    logic idle_pol;
    logic clk_phase_select;
    logic sck_master;
    logic so_drive;
  } sssp_portg_s;

  typedef enum {
    SSSP_IDLE,
    SSSP_SHIFT
  } sssp_state_e;

endpackage

// file: logic/sssp_top.sv
// Synchronous serial shift port, 8 bits, master or slave, AXI4-Lite registers.
// Assumes core_clk_i is the instruction-cycle clock and the link pins are asynchronous.
//
// Notes on behaviour
// - Master shift clock period is 2, 4 or 8 cycles per rate select bits.
// - Writing busy set starts shifting the serial shift register.
// - Busy clears itself after eight bits have been shifted.
// - Software clearing busy mid transfer stops shifting early.
// - Completion of eight bits raises an interrupt pulse when enabled.
// - In master mode the block makes the clock and starts every exchange.
// - Data out and clock reach the pins only while the port is selected.
// - Data out is driven when its drive bit is one, else released.
// - Clock source bit one means internal master clock, zero means external.
// - Master clock stops after eight pulses and busy clears.
// - Loading the shift register during an active clock phase is undefined.
// - Setting busy while external clock is active may shorten first clock.
// - Clock idle level comes from the idle polarity bit.
// - Normal phase samples on rising edge and changes output on falling edge.
// - Alternate phase samples on falling edge, changes output on rising edge.
// - Effective phase is phase select XOR idle polarity.
// - Phase select resets to zero, giving normal phase with idle low.
// - An 8-bit shift register takes data in and drives data out.
// - Port works only while the select bit of the control register is one.
`timescale 1ns/1ps
`include "sssp_defines.svh"

module sssp_top
  import sssp_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     resetn_i,
  input  wire logic [`SSSP_ADDR_W-1:0]  s_axi_awaddr_i,
  input  wire logic                     s_axi_awvalid_i,
  output logic                          s_axi_awready_o,
  input  wire logic [31:0]              s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  input  wire logic                     s_axi_wvalid_i,
  output logic                          s_axi_wready_o,
  output logic [1:0]                    s_axi_bresp_o,
  output logic                          s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  input  wire logic [`SSSP_ADDR_W-1:0]  s_axi_araddr_i,
  input  wire logic                     s_axi_arvalid_i,
  output logic                          s_axi_arready_o,
  output logic [31:0]                   s_axi_rdata_o,
  output logic [1:0]                    s_axi_rresp_o,
  output logic                          s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  input  wire logic                     shift_clk_i,
  output logic                          shift_clk_o,
  output logic                          shift_clk_oe_o,
  input  wire logic                     sdi_i,
  output logic                          sdo_o,
  output logic                          sdo_oe_o,
  output logic                          irq_o
);

  function automatic logic [2:0] half_len(input sssp_ctrl_s c);
    if (c.clk_rate_sel_hi) begin
      half_len = `SSSP_HALF_DIV8;
    end else if (c.clk_rate_sel_lo) begin
      half_len = `SSSP_HALF_DIV4;
    end else begin
      half_len = `SSSP_HALF_DIV2;
    end
  endfunction
  function automatic logic addr_hit(input logic [`SSSP_ADDR_W-1:0] a, input logic [`SSSP_ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  logic                    rst_meta_reg;
  logic                    rst_n_reg;
  logic                    sck_meta_reg;
  logic                    sck_sync_reg;
  logic                    sck_last_reg;
  logic                    sdi_meta_reg;
  logic                    sdi_sync_reg;
  sssp_ctrl_s              ctrl_reg;
  sssp_portg_s             portg_reg;
  sssp_state_e             state_reg;
  logic [7:0]              shift_reg;
  logic [3:0]              bit_cnt_reg;
  logic [2:0]              div_cnt_reg;
  logic                    sck_int_reg;
  logic                    sdo_reg;
  logic                    sdo_oe_reg;
  logic                    sck_oe_reg;
  logic                    irq_reg;
  logic                    awready_reg;
  logic                    wready_reg;
  logic [`SSSP_ADDR_W-1:0] aw_addr_reg;
  logic [7:0]              w_data_reg;
  logic                    w_strb_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    arready_reg;
  logic                    rvalid_reg;
  logic [31:0]             rdata_reg;
  logic [1:0]              rresp_reg;
  logic                    wr_fire;
  logic                    wr_ok;
  logic                    wr_ctrl;
  logic                    wr_stat;
  logic                    wr_data;
  logic                    wr_portg;
  logic                    shifting;
  logic                    alt_phase;
  logic                    tick;
  logic                    rise;
  logic                    fall;
  logic                    sample_edge;
  logic                    out_edge;
  logic                    done;
  logic [31:0]             rd_word;
  logic                    rd_ok;

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Link pins are asynchronous; first flop feeds only the second
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sck_meta_reg <= 1'b0;
      sck_sync_reg <= 1'b0;
      sck_last_reg <= 1'b0;
      sdi_meta_reg <= 1'b0;
      sdi_sync_reg <= 1'b0;
    end else begin
      sck_meta_reg <= shift_clk_i;
      sck_sync_reg <= sck_meta_reg;
      sck_last_reg <= sck_sync_reg;
      sdi_meta_reg <= sdi_i;
      sdi_sync_reg <= sdi_meta_reg;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign wr_fire  = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_ok    = wr_fire && w_strb_reg;
  assign wr_ctrl  = wr_ok && addr_hit(aw_addr_reg, `SSSP_OFF_CTRL);
  assign wr_stat  = wr_ok && addr_hit(aw_addr_reg, `SSSP_OFF_STAT);
  assign wr_data  = wr_ok && addr_hit(aw_addr_reg, `SSSP_OFF_DATA);
  assign wr_portg = wr_ok && addr_hit(aw_addr_reg, `SSSP_OFF_PORTG);

  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      awready_reg <= 1'b1;
      aw_addr_reg <= '0;
    end else if (awready_reg && s_axi_awvalid_i) begin
      awready_reg <= 1'b0;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wready_reg <= 1'b1;
      w_data_reg <= '0;
      w_strb_reg <= 1'b0;
    end else if (wready_reg && s_axi_wvalid_i) begin
      wready_reg <= 1'b0;
      w_data_reg <= s_axi_wdata_i[7:0];
      w_strb_reg <= s_axi_wstrb_i[0];
    end else if (wr_fire) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `SSSP_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (addr_hit(aw_addr_reg, `SSSP_OFF_CTRL) || addr_hit(aw_addr_reg, `SSSP_OFF_STAT) ||
                     addr_hit(aw_addr_reg, `SSSP_OFF_DATA) || addr_hit(aw_addr_reg, `SSSP_OFF_PORTG)) ?
                    `SSSP_RESP_OKAY : `SSSP_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // AXI4-Lite read, one outstanding
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr_i)
      `SSSP_OFF_CTRL:  rd_word[3:0] = ctrl_reg;
      `SSSP_OFF_STAT: begin
        rd_word[`SSSP_STAT_BUSY]                      = (state_reg == SSSP_SHIFT);
        rd_word[`SSSP_STAT_SCK]                       = portg_reg.sck_master ? sck_int_reg : sck_sync_reg;
        rd_word[`SSSP_STAT_CNT_LSB+3:`SSSP_STAT_CNT_LSB] = bit_cnt_reg;
      end
      `SSSP_OFF_DATA:  rd_word[7:0] = shift_reg;
      `SSSP_OFF_PORTG: rd_word[3:0] = portg_reg;
      default:         rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `SSSP_RESP_OKAY;
    end else if (arready_reg && s_axi_arvalid_i) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_ok ? `SSSP_RESP_OKAY : `SSSP_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= `SSSP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= w_data_reg[3:0];
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      portg_reg <= `SSSP_PORTG_RST;
    end else if (wr_portg) begin
      portg_reg <= w_data_reg[3:0];
    end
  end

  // Edge selection for both clock sources
  assign shifting    = (state_reg == SSSP_SHIFT);
  assign alt_phase   = portg_reg.clk_phase_select ^ portg_reg.idle_pol;
  assign tick        = shifting && portg_reg.sck_master && (div_cnt_reg == half_len(ctrl_reg) - 3'h1);
  assign rise        = portg_reg.sck_master ? (tick && !sck_int_reg) : (sck_sync_reg && !sck_last_reg);
  assign fall        = portg_reg.sck_master ? (tick && sck_int_reg) : (!sck_sync_reg && sck_last_reg);
  assign sample_edge = shifting && (alt_phase ? fall : rise);
  assign out_edge    = shifting && (alt_phase ? rise : fall);
  // Sixteenth edge returns the clock to idle; it is a sample edge only when output leads
  assign done        = (portg_reg.clk_phase_select && sample_edge && bit_cnt_reg == `SSSP_LAST_BIT) ||
                       (!portg_reg.clk_phase_select && out_edge && bit_cnt_reg == `SSSP_BITS);

  // Busy flag; a software set wins over a completion in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= SSSP_IDLE;
    end else begin
      case (state_reg)
        SSSP_IDLE: begin
          if (wr_stat && w_data_reg[`SSSP_STAT_BUSY] && ctrl_reg.serial_port_select) begin
            state_reg <= SSSP_SHIFT;
          end
        end
        SSSP_SHIFT: begin
          if (wr_stat && w_data_reg[`SSSP_STAT_BUSY]) begin
            state_reg <= SSSP_SHIFT;
          end else if (wr_stat || done || !ctrl_reg.serial_port_select) begin
            state_reg <= SSSP_IDLE;
          end
        end
        default: state_reg <= SSSP_IDLE;
      endcase
    end
  end

  // Master clock divider
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      div_cnt_reg <= '0;
    end else if (!shifting || !portg_reg.sck_master || tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end
  // Internal clock rests at the idle level outside a transfer
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sck_int_reg <= 1'b0;
    end else if (!shifting || !portg_reg.sck_master || done) begin
      sck_int_reg <= portg_reg.idle_pol;
    end else if (tick) begin
      sck_int_reg <= !sck_int_reg;
    end
  end

  // Bit counter restarts on each busy set
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bit_cnt_reg <= '0;
    end else if (wr_stat && w_data_reg[`SSSP_STAT_BUSY]) begin
      bit_cnt_reg <= '0;
    end else if (sample_edge) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // A load during an active clock phase wins and corrupts the frame
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shift_reg <= `SSSP_DATA_RST;
    end else if (wr_data) begin
      shift_reg <= w_data_reg;
    end else if (sample_edge) begin
      shift_reg <= {shift_reg[6:0], sdi_sync_reg};
    end
  end

  // Serial output follows the MSB; changes only on the output edge while busy
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sdo_reg <= 1'b0;
    end else if (!shifting || out_edge) begin
      sdo_reg <= shift_reg[7];
    end
  end

  // Pin drive enables
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sdo_oe_reg <= 1'b0;
      sck_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= ctrl_reg.serial_port_select && portg_reg.so_drive;
      sck_oe_reg <= ctrl_reg.serial_port_select && portg_reg.sck_master;
    end
  end

  // Completion pulse; no pending latch, the core takes it as a request
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= done && ctrl_reg.irq_en && !wr_stat;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign shift_clk_o     = sck_int_reg;
  assign shift_clk_oe_o  = sck_oe_reg;
  assign sdo_o           = sdo_reg;
  assign sdo_oe_o        = sdo_oe_reg;
  assign irq_o           = irq_reg;

endmodule

// file: tb/serial_sync_shift_port_bench.sv
// Self-checking bench for the serial shift port: bus tasks, scenarios, report.
// Assumes the far-end model and the checker are compiled before this file.
`timescale 1ns/1ps
`include "sssp_defines.svh"
module serial_sync_shift_port_bench
  import sssp_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, sdo, sdo_oe, irq, far_sck, far_sdi;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  far_tx = 8'h00;
  logic [7:0]  far_rx;
  logic        far_alt = 1'b0, far_idle = 1'b0, far_load = 1'b0, far_run = 1'b0, sck_prev = 1'b0;
  wire         sck_line = sck_oe ? sck_o : far_sck;
  int          bad_count = 0, tests_run = 0, ntog = 0, nirq = 0, cyc = 0, ftog = 0, ltog = 0, cirq = 0;
  always #10 clk = ~clk;
  sssp_top dut (
    .core_clk_i(clk), .resetn_i(rstn), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .shift_clk_i(sck_line),
    .shift_clk_o(sck_o), .shift_clk_oe_o(sck_oe), .sdi_i(far_sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .irq_o(irq));
  sssp_far_end u_far (.sck_i(sck_line), .sdo_i(sdo), .alt_i(far_alt), .idle_i(far_idle), .tx_i(far_tx),
    .load_i(far_load), .run_i(far_run), .sck_o(far_sck), .sdi_o(far_sdi), .rx_o(far_rx));
  // Values seen at each edge, before that edge's updates land
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (sck_o !== sck_prev) begin
      if (ntog == 0)
        ftog = cyc;
      ltog = cyc;
      ntog = ntog + 1;
    end
    if (irq === 1'b1) begin
      cirq = cyc;
      nirq = nirq + 1;
    end
    sck_prev = sck_o;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    if (wr) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (arready)
        arvalid <= 1'b0;
    end while (!(wr ? bvalid : rvalid) && n < 40);
    bready <= 1'b0;
    rready <= 1'b0;
    q = rdata;
    if (!(wr ? bvalid : rvalid)) begin
      bad_count++;
      final_report();
    end
    chk({30'h0, wr ? bresp : rresp}, {30'h0, er});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, `SSSP_RESP_OKAY, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, `SSSP_RESP_OKAY, q);
    chk(q & m, e);
  endtask
  task automatic load_far();
    far_load <= 1'b1;
    @(posedge clk);
    far_load <= 1'b0;
  endtask
  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim && nirq == 0; n++)
      @(posedge clk);
    if (nirq == 0) begin
      bad_count++;
      final_report();
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic reset_vals();
    rd(`SSSP_OFF_CTRL, 32'hf, {28'h0, `SSSP_CTRL_RST});
    rd(`SSSP_OFF_PORTG, 32'hf, {28'h0, `SSSP_PORTG_RST});
    rd(`SSSP_OFF_DATA, 32'hff, {24'h0, `SSSP_DATA_RST});
    rd(`SSSP_OFF_STAT, 32'h1, 32'h0);
  endtask
  task automatic refuse();
    logic [31:0] q;
    wr(`SSSP_OFF_PORTG, 8'h03);
    wr(`SSSP_OFF_CTRL, 8'h08);
    ntog = 0;
    wr(`SSSP_OFF_STAT, 8'h01);
    repeat (20) @(posedge clk);
    chk({ntog[3:0], sck_oe, sdo_oe}, 6'h00);
    rd(`SSSP_OFF_STAT, 32'h1, 32'h0);
    wr(`SSSP_OFF_CTRL, 8'h01);
    wr(`SSSP_OFF_PORTG, 8'h02);
    repeat (2) @(posedge clk);
    chk({sck_oe, sdo_oe}, 2'b10);
    bus(1'b1, 8'h10, 8'h00, `SSSP_RESP_SLVERR, q);
    bus(1'b0, 8'h14, 8'h00, `SSSP_RESP_SLVERR, q);
  endtask
  task automatic master_run(input logic [1:0] rate, input logic alt, input logic idle);
    sssp_portg_s pg;
    int h;
    pg = '{idle_pol: idle, clk_phase_select: alt, sck_master: 1'b1, so_drive: 1'b1};
    h = rate[1] ? 4 : (rate[0] ? 2 : 1);
    far_idle <= idle;
    far_alt <= alt ^ idle;
    far_tx <= 8'h6d;
    wr(`SSSP_OFF_PORTG, {4'h0, pg});
    wr(`SSSP_OFF_CTRL, {4'h0, 1'b1, rate, 1'b1});
    wr(`SSSP_OFF_DATA, 8'hb4);
    load_far();
    chk(sck_o, idle);
    ntog = 0;
    nirq = 0;
    wr(`SSSP_OFF_STAT, 8'h01);
    wait_irq(300);
    chk(ntog, 16);
    chk(ltog - ftog, 15 * h);
    chk(cirq, ltog);
    chk(far_rx, 8'hb4);
    chk({sck_o, sck_oe, sdo_oe}, {idle, 2'b11});
    rd(`SSSP_OFF_STAT, 32'h1, 32'h0);
    // Fast rates outrun the input synchroniser, so received data is judged only at the slow rate
    if (rate[1])
      rd(`SSSP_OFF_DATA, 32'hff, 32'h6d);
  endtask
  task automatic abort_run();
    int n;
    wr(`SSSP_OFF_PORTG, 8'h03);
    wr(`SSSP_OFF_CTRL, 8'h09);
    ntog = 0;
    nirq = 0;
    wr(`SSSP_OFF_STAT, 8'h01);
    for (n = 0; n < 50 && ntog < 4; n++)
      @(posedge clk);
    if (ntog < 4) begin
      bad_count++;
      final_report();
    end
    wr(`SSSP_OFF_STAT, 8'h00);
    repeat (30) @(posedge clk);
    chk({ntog < 16, nirq == 0, sck_o}, 3'b110);
    rd(`SSSP_OFF_STAT, 32'h1, 32'h0);
  endtask
  task automatic slave_run();
    far_idle <= 1'b0;
    far_alt <= 1'b0;
    far_tx <= 8'h96;
    wr(`SSSP_OFF_PORTG, 8'h01);
    wr(`SSSP_OFF_DATA, 8'h5a);
    load_far();
    nirq = 0;
    wr(`SSSP_OFF_STAT, 8'h01);
    far_run <= 1'b1;
    @(posedge clk);
    far_run <= 1'b0;
    wait_irq(400);
    chk({nirq[3:0], sck_oe}, 5'h02);
    chk(far_rx, 8'h5a);
    rd(`SSSP_OFF_DATA, 32'hff, 32'h96);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    reset_vals();
    refuse();
    for (int i = 0; i < 4; i++)
      master_run(i[1:0], i[0], i[1]);
    abort_run();
    slave_run();
    final_report();
  end
endmodule
bind sssp_top sssp_props u_props (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .shift_clk_o(shift_clk_o), .shift_clk_oe_o(shift_clk_oe_o), .irq_o(irq_o));

// file: tb/sssp_far_end.sv
// Behavioural far-end peer: shifts on the link clock, and makes the clock for slave runs.
// Assumes sck_i is the resolved clock line and alt_i the effective phase.
`timescale 1ns/1ps
module sssp_far_end (
  input  wire logic       sck_i,
  input  wire logic       sdo_i,
  input  wire logic       alt_i,
  input  wire logic       idle_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       load_i,
  input  wire logic       run_i,
  output logic            sck_o,
  output logic            sdi_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sh_reg = 8'h00;
  logic       first_reg = 1'b0;
  logic       ph_reg = 1'b0;
  logic       busy_reg = 1'b0;
  int         edges = 0;
  assign sck_o = idle_i ^ ph_reg;
  // Outside a frame show the inverse of the last bit, never a stale copy
  assign sdi_o = busy_reg ? sh_reg[7] : ~sh_reg[7];
  always @(posedge load_i) begin
    sh_reg = tx_i;
    first_reg = 1'b1;
    busy_reg = 1'b1;
    edges = 0;
    rx_o = 8'h00;
  end
  always @(sck_i) begin
    if (busy_reg) begin
      if ((sck_i ^ alt_i) === 1'b1)
        rx_o = {rx_o[6:0], sdo_i};
      else if (!first_reg)
        sh_reg = {sh_reg[6:0], 1'b0};
      first_reg = 1'b0;
      edges++;
      if (edges == 16)
        busy_reg = 1'b0;
    end
  end
  // Phase offset keeps the link clock unrelated to the core clock
  always @(posedge run_i) begin
    #7;
    repeat (16) begin
      ph_reg = ~ph_reg;
      #80;
    end
  end
endmodule

// file: tb/sssp_properties.sv
// Concurrent checks on the ports of the serial shift port top.
// Assumes it is bound to sssp_top from the bench top file.
`timescale 1ns/1ps
module sssp_props (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic shift_clk_o,
  input wire logic shift_clk_oe_o,
  input wire logic irq_o
);
  logic [2:0] gap_reg;
  // Saturates, so a long idle never looks like a short half period
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      gap_reg <= 3'h7;
    else if ($changed(shift_clk_o))
      gap_reg <= 3'h1;
    else if (gap_reg != 3'h7)
      gap_reg <= gap_reg + 3'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  AST_WR_RESP: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  AST_B_DONE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response not retired");
  AST_RD_RESP: assert property (rd_taken |=> s_axi_rvalid_o)
    else $error("read data late");
  AST_R_DONE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read data not retired");
  AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while data pending");
  AST_AW_BLOCK: assert property (wr_taken |=> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write readies not dropped after take");
  AST_IRQ_PULSE: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  AST_HALF_PERIOD: assert property ($changed(shift_clk_o) && shift_clk_oe_o && gap_reg < 3'h5
    |-> gap_reg inside {3'h1, 3'h2, 3'h4}) else $error("bad shift clock half period");
  AST_IRQ_LAST: assert property (irq_o && shift_clk_oe_o |-> $changed(shift_clk_o))
    else $error("interrupt not together with last clock edge");
endmodule
